//--- inc/gef_consts.svh
// Summary of operation
// - Start field picks far gain point nine..twelve
// - Far gain field multiplies by two to code
// - Far gain from start point to record end
// - Near gain same coding, before start point
// - Eight-bit read/write checksum register kept
// - Control bit seven enables data dumping
// - Passcode 0xD in bits 6:3 unlocks programming
// - Read-only bit two reports programming success
// - Writing bit one reloads stored data
// - Writing bit zero programs registers into storage
// - Filter coefficient high 41h, low 42h bytes
// - Far gain above eight scales noise level
`ifndef GEF_CONSTS_SVH
`define GEF_CONSTS_SVH

// ==========================================================
// Register offsets
`define GEF_OFS_GAIN 8'h2A
`define GEF_OFS_CRC 8'h2B
`define GEF_OFS_CTRL 8'h40
`define GEF_OFS_A2H 8'h41
`define GEF_OFS_A2L 8'h42
`define GEF_OFS_STAT 8'h50
`define GEF_OFS_MASK 8'h51

// ==========================================================
// Field positions
`define GEF_ST_HI 7
`define GEF_ST_LO 6
`define GEF_LR_HI 5
`define GEF_LR_LO 3
`define GEF_SR_HI 2
`define GEF_SR_LO 0
`define GEF_CTL_DUMP 7
`define GEF_CTL_PASS_HI 6
`define GEF_CTL_PASS_LO 3
`define GEF_CTL_OK 2
`define GEF_CTL_RLD 1
`define GEF_CTL_PRG 0
`define GEF_EV_PDONE 0
`define GEF_EV_LDONE 1
`define GEF_EV_BADPASS 2

// ==========================================================
// Values
`define GEF_RESET_BYTE 8'h00
`define GEF_RESET_EV 3'h0
`define GEF_PASSCODE 4'hD
`define GEF_GAIN_MAX_CODE 3'h5
`define GEF_FIRST_LR_POINT 4'h9
`define GEF_NOISE_KNEE 3'h3
`define GEF_EE_LAST 2'h3

`endif

//--- inc/gef_pkg.sv
`default_nettype none
`include "gef_consts.svh"
package gef_pkg;
  typedef enum logic [1:0] {GEF_IDLE, GEF_PROG, GEF_LOAD} gef_state_t;

  // Invalid codes fall back to unity gain
  function automatic logic [2:0] gef_gain_shift(input logic [2:0] code);
    return (code > `GEF_GAIN_MAX_CODE) ? 3'h0 : code;
  endfunction

  function automatic logic gef_code_bad(input logic [2:0] code);
    return code > `GEF_GAIN_MAX_CODE;
  endfunction
endpackage
`default_nettype wire

//--- hw/gef_ee_mem.sv
`timescale 1ns/100ps
`default_nettype none
`include "gef_consts.svh"
module gef_ee_mem import gef_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [1:0] rd_addr,
  output logic [7:0] rd_data
);
  // ========================================================
  // Storage image, no reset like a real array
  logic [7:0] mem [0:3];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= `GEF_RESET_BYTE;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

//--- hw/gef_gain_apply.sv
`timescale 1ns/100ps
`default_nettype none
`include "gef_consts.svh"
module gef_gain_apply import gef_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] gain_ctrl,
  input wire logic [3:0] cur_point,
  input wire logic rec_active,
  input wire logic echo_valid,
  input wire logic [7:0] echo_sample,
  input wire logic [4:0] noise_floor_setting,
  output logic [12:0] gain_echo,
  output logic gain_valid,
  output logic [6:0] noise_scaled,
  output logic gain_code_err
);
  logic [1:0] st;
  logic [2:0] lr;
  logic [2:0] sr;
  logic [3:0] start_point;
  logic far_zone;
  logic [2:0] shift;
  logic [2:0] lr_sh;

  assign st = gain_ctrl[`GEF_ST_HI:`GEF_ST_LO];
  assign lr = gain_ctrl[`GEF_LR_HI:`GEF_LR_LO];
  assign sr = gain_ctrl[`GEF_SR_HI:`GEF_SR_LO];
  assign start_point = `GEF_FIRST_LR_POINT + {2'h0, st};
  // Far zone lasts to record end, never before start point
  assign far_zone = rec_active && (cur_point >= start_point);
  assign lr_sh = gef_gain_shift(lr);
  assign shift = far_zone ? lr_sh : gef_gain_shift(sr);

  // ========================================================
  // Echo scaling
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_echo <= 13'h0000;
      gain_valid <= 1'b0;
    end else begin
      gain_valid <= echo_valid;
      if (echo_valid) begin
        gain_echo <= {5'h00, echo_sample} << shift;
      end
    end
  end

  // ========================================================
  // Noise level follows far gain above x8
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      noise_scaled <= 7'h00;
    end else if (lr_sh > `GEF_NOISE_KNEE) begin
      noise_scaled <= {2'h0, noise_floor_setting}
        << (lr_sh - `GEF_NOISE_KNEE);
    end else begin
      noise_scaled <= {2'h0, noise_floor_setting};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_code_err <= 1'b0;
    end else begin
      gain_code_err <= gef_code_bad(lr) | gef_code_bad(sr);
    end
  end
endmodule
`default_nettype wire

//--- hw/gef_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "gef_consts.svh"
module gef_regs import gef_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic ee_fault,
  output logic dump_enable,
  output logic ee_busy,
  output logic [15:0] bandpass_a2_coeff,
  input wire logic [3:0] cur_point,
  input wire logic rec_active,
  input wire logic echo_valid,
  input wire logic [7:0] echo_sample,
  input wire logic [4:0] noise_floor_setting,
  output logic [12:0] gain_echo,
  output logic gain_valid,
  output logic [6:0] noise_scaled,
  output logic gain_code_err
);
  // ========================================================
  // Declarations
  logic [7:0] gain_reg;
  logic [7:0] crc_reg;
  logic [7:0] a2h_reg;
  logic [7:0] a2l_reg;
  logic dump_reg;
  logic [3:0] pass_reg;
  logic ok_reg;
  logic rld_reg;
  logic prg_reg;
  logic [2:0] stat_reg;
  logic [2:0] stat_next;
  logic [2:0] mask_reg;
  gef_state_t state_reg;
  logic [1:0] idx_reg;
  logic issued_reg;
  logic rd_vld_reg;
  logic [1:0] rd_idx_reg;
  logic fault_reg;
  logic wr_gain, wr_crc, wr_ctrl, wr_a2h, wr_a2l;
  logic pass_ok_wr;
  logic start_prog;
  logic start_load;
  logic prog_done;
  logic load_done;
  logic bad_pass;
  logic mem_wr;
  logic mem_rd;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] ctrl_view;
  logic [2:0] ev_set;

  // Byte image order: gain, checksum, coefficient high, low
  function automatic logic [7:0] pick_byte(input logic [1:0] i,
      input logic [7:0] b0, input logic [7:0] b1,
      input logic [7:0] b2, input logic [7:0] b3);
    unique case (i)
      2'h0: return b0;
      2'h1: return b1;
      2'h2: return b2;
      2'h3: return b3;
    endcase
  endfunction

  // ========================================================
  // Decode
  assign wr_gain = reg_wr && (reg_addr == `GEF_OFS_GAIN);
  assign wr_crc = reg_wr && (reg_addr == `GEF_OFS_CRC);
  assign wr_ctrl = reg_wr && (reg_addr == `GEF_OFS_CTRL);
  assign wr_a2h = reg_wr && (reg_addr == `GEF_OFS_A2H);
  assign wr_a2l = reg_wr && (reg_addr == `GEF_OFS_A2L);
  assign pass_ok_wr = reg_wdata[`GEF_CTL_PASS_HI:`GEF_CTL_PASS_LO]
    == `GEF_PASSCODE;
  // Wrong passcode: trigger dropped, event flagged
  assign bad_pass = wr_ctrl && reg_wdata[`GEF_CTL_PRG] && !pass_ok_wr
    && (state_reg == GEF_IDLE);
  assign start_prog = (state_reg == GEF_IDLE) && prg_reg;
  assign start_load = (state_reg == GEF_IDLE) && !prg_reg && rld_reg;
  assign prog_done = (state_reg == GEF_PROG) && (idx_reg == `GEF_EE_LAST);
  assign load_done = (state_reg == GEF_LOAD) && rd_vld_reg
    && (rd_idx_reg == `GEF_EE_LAST);
  assign mem_wr = state_reg == GEF_PROG;
  assign mem_rd = (state_reg == GEF_LOAD) && !issued_reg;
  assign mem_wdata = pick_byte(idx_reg, gain_reg, crc_reg,
    a2h_reg, a2l_reg);
  assign ctrl_view = {dump_reg, pass_reg, ok_reg, rld_reg, prg_reg};

  // ========================================================
  // Configuration bytes; reload data wins over software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_reg <= `GEF_RESET_BYTE;
    end else if (rd_vld_reg && rd_idx_reg == 2'h0) begin
      gain_reg <= mem_rdata;
    end else if (wr_gain) begin
      gain_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crc_reg <= `GEF_RESET_BYTE;
    end else if (rd_vld_reg && rd_idx_reg == 2'h1) begin
      crc_reg <= mem_rdata;
    end else if (wr_crc) begin
      crc_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a2h_reg <= `GEF_RESET_BYTE;
      a2l_reg <= `GEF_RESET_BYTE;
    end else begin
      if (rd_vld_reg && rd_idx_reg == 2'h2) begin
        a2h_reg <= mem_rdata;
      end else if (wr_a2h) begin
        a2h_reg <= reg_wdata;
      end
      if (rd_vld_reg && rd_idx_reg == 2'h3) begin
        a2l_reg <= mem_rdata;
      end else if (wr_a2l) begin
        a2l_reg <= reg_wdata;
      end
    end
  end

  // ========================================================
  // Control register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dump_reg <= 1'b0;
      pass_reg <= 4'h0;
    end else if (wr_ctrl) begin
      dump_reg <= reg_wdata[`GEF_CTL_DUMP];
      pass_reg <= reg_wdata[`GEF_CTL_PASS_HI:`GEF_CTL_PASS_LO];
    end
  end

  // Triggers set only when idle; writes of zero never cancel
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prg_reg <= 1'b0;
      rld_reg <= 1'b0;
    end else begin
      if (prog_done) begin
        prg_reg <= 1'b0;
      end else if (wr_ctrl && state_reg == GEF_IDLE
          && reg_wdata[`GEF_CTL_PRG] && pass_ok_wr) begin
        prg_reg <= 1'b1;
      end
      if (load_done) begin
        rld_reg <= 1'b0;
      end else if (wr_ctrl && state_reg == GEF_IDLE
          && reg_wdata[`GEF_CTL_RLD]) begin
        rld_reg <= 1'b1;
      end
    end
  end

  // Success only changes at the end of a program run
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ok_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      if (start_prog) begin
        fault_reg <= 1'b0;
      end else if (state_reg == GEF_PROG && ee_fault) begin
        fault_reg <= 1'b1;
      end
      if (prog_done) begin
        ok_reg <= !(fault_reg || ee_fault);
      end
    end
  end

  // ========================================================
  // Storage sequencer; program has priority over reload
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= GEF_IDLE;
      idx_reg <= 2'h0;
      issued_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        GEF_IDLE: begin
          idx_reg <= 2'h0;
          issued_reg <= 1'b0;
          if (start_prog) begin
            state_reg <= GEF_PROG;
          end else if (start_load) begin
            state_reg <= GEF_LOAD;
          end
        end
        GEF_PROG: begin
          idx_reg <= idx_reg + 2'h1;
          if (prog_done) begin
            state_reg <= GEF_IDLE;
          end
        end
        GEF_LOAD: begin
          if (!issued_reg) begin
            idx_reg <= idx_reg + 2'h1;
            issued_reg <= idx_reg == `GEF_EE_LAST;
          end
          if (load_done) begin
            state_reg <= GEF_IDLE;
          end
        end
      endcase
    end
  end

  // Read data arrive one cycle after the request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_vld_reg <= 1'b0;
      rd_idx_reg <= 2'h0;
    end else begin
      rd_vld_reg <= mem_rd;
      rd_idx_reg <= idx_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ee_busy <= 1'b0;
    end else begin
      ee_busy <= (state_reg != GEF_IDLE) || prg_reg || rld_reg;
    end
  end

  // ========================================================
  // Events: set beats the clear of a status read
  assign ev_set = {bad_pass, load_done, prog_done};

  always_comb begin
    stat_next = stat_reg;
    if (reg_rd && reg_addr == `GEF_OFS_STAT) begin
      stat_next = `GEF_RESET_EV;
    end
    stat_next = stat_next | ev_set;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_reg <= `GEF_RESET_EV;
    end else begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= `GEF_RESET_EV;
    end else if (reg_wr && reg_addr == `GEF_OFS_MASK) begin
      mask_reg <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_next & mask_reg);
    end
  end

  // ========================================================
  // Read port; unmapped reads return zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `GEF_RESET_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `GEF_OFS_GAIN: reg_rdata <= gain_reg;
        `GEF_OFS_CRC: reg_rdata <= crc_reg;
        `GEF_OFS_CTRL: reg_rdata <= ctrl_view;
        `GEF_OFS_A2H: reg_rdata <= a2h_reg;
        `GEF_OFS_A2L: reg_rdata <= a2l_reg;
        `GEF_OFS_STAT: reg_rdata <= {5'h00, stat_reg};
        `GEF_OFS_MASK: reg_rdata <= {5'h00, mask_reg};
        default: reg_rdata <= `GEF_RESET_BYTE;
      endcase
    end else begin
      reg_rdata <= `GEF_RESET_BYTE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dump_enable <= 1'b0;
      bandpass_a2_coeff <= 16'h0000;
    end else begin
      dump_enable <= dump_reg;
      bandpass_a2_coeff <= {a2h_reg, a2l_reg};
    end
  end

  // ========================================================
  // Submodules
  gef_ee_mem u_mem (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(mem_wr),
    .wr_addr(idx_reg),
    .wr_data(mem_wdata),
    .rd_en(mem_rd),
    .rd_addr(idx_reg),
    .rd_data(mem_rdata)
  );

  gef_gain_apply u_gain (
    .clk(clk),
    .arst_n(arst_n),
    .gain_ctrl(gain_reg),
    .cur_point(cur_point),
    .rec_active(rec_active),
    .echo_valid(echo_valid),
    .echo_sample(echo_sample),
    .noise_floor_setting(noise_floor_setting),
    .gain_echo(gain_echo),
    .gain_valid(gain_valid),
    .noise_scaled(noise_scaled),
    .gain_code_err(gain_code_err)
  );
endmodule
`default_nettype wire

//--- tb/gef_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
module gef_regs_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic dump_enable,
  input wire logic ee_busy,
  input wire logic [15:0] bandpass_a2_coeff,
  input wire logic gain_code_err
);
  // ==========================================================
  // Shared timing
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence ctl_wr;
    reg_wr && reg_addr == 8'h40 && !ee_busy;
  endsequence
  // Status read while idle, then no write that could raise an event
  sequence status_rd;
    reg_rd && reg_addr == 8'h50 && !ee_busy ##1 !reg_wr && !ee_busy;
  endsequence

  // ==========================================================
  // Checks
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data driven without a read");
  a_busy_start:
    assert property (ctl_wr ##0 (reg_wdata[1] || reg_wdata[0] &&
      reg_wdata[6:3] == 4'hD) |-> ##[1:2] ee_busy)
    else $error("trigger did not start an operation");
  a_busy_bound:
    assert property ($rose(ee_busy) |-> ##[1:20] !ee_busy)
    else $error("operation did not complete in time");
  a_bad_pass:
    assert property (ctl_wr ##0 reg_wdata[1:0] == 2'b01 &&
      reg_wdata[6:3] != 4'hD |=> !ee_busy [*3])
    else $error("program ran without passcode");
  a_irq_clear:
    assert property (status_rd |=> !irq)
    else $error("irq stayed up after status read");
  a_coeff_high:
    assert property (reg_wr && reg_addr == 8'h41 && !ee_busy |=> ##1
      bandpass_a2_coeff[15:8] == $past(reg_wdata, 2))
    else $error("coefficient high byte wrong");
  a_coeff_low:
    assert property (reg_wr && reg_addr == 8'h42 && !ee_busy |=> ##1
      bandpass_a2_coeff[7:0] == $past(reg_wdata, 2))
    else $error("coefficient low byte wrong");
  a_dump_follow:
    assert property (reg_wr && reg_addr == 8'h40 |=> ##1
      dump_enable == $past(reg_wdata[7], 2))
    else $error("dump enable does not follow control bit");
  a_code_err:
    assert property (reg_wr && reg_addr == 8'h2A && !ee_busy &&
      (reg_wdata[5:4] == 2'b11 || reg_wdata[2:1] == 2'b11)
      |-> ##[1:2] gain_code_err)
    else $error("invalid gain code not flagged");
endmodule
bind gef_regs gef_regs_props gef_regs_props_i (.*);
`default_nettype wire

//--- tb/gef_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module gef_regs_bench;
  logic clk, arst_n, reg_wr, reg_rd, ee_fault, rec_active, echo_valid;
  logic [7:0] reg_addr, reg_wdata, echo_sample, reg_rdata, g;
  logic [3:0] cur_point, cp;
  logic [4:0] noise_floor_setting;
  logic irq, dump_enable, ee_busy, gain_valid, gain_code_err, far, rd_d;
  logic [15:0] bandpass_a2_coeff;
  logic [12:0] gain_echo;
  logic [6:0] noise_scaled, nz;
  logic [2:0] code, sh;
  logic [31:0] r;
  logic [7:0] d [4];
  logic [7:0] ofs [4] = '{8'h2A, 8'h2B, 8'h41, 8'h42};
  logic [15:0] rd_q [$];
  logic [12:0] g_q [$];
  int n_mismatch, compares, seed, i;

  gef_regs gef_regs_i (.*);

  always #50 clk = ~clk;

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back({a, e});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Bounded wait; status and irq land a cycle before busy drops
  task automatic idle;
    int k;
    repeat (2) @(posedge clk);
    for (k = 0; k < 40 && ee_busy !== 1'b0; k++) @(posedge clk);
    if (ee_busy !== 1'b0) chk("ee_busy", 16'h0000, {15'h0, ee_busy});
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Result monitor
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      chk("rdata", {8'h0, rd_q[0][7:0]}, {8'h0, reg_rdata});
      void'(rd_q.pop_front());
    end
    if (gain_valid === 1'b1) begin
      chk("gain_echo", {3'h0, g_q.pop_front()},
        {3'h0, gain_echo});
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {reg_wr, reg_rd, ee_fault, rec_active, echo_valid} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    echo_sample = 8'h00;
    cur_point = 4'h0;
    noise_floor_setting = 5'h00;
    seed = 61;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 4; i++) rd(ofs[i], 8'h00);
    rd(8'h40, 8'h00);
    for (i = 0; i < 4; i++) d[i] = 8'($random(seed));
    for (i = 0; i < 4; i++) wr(ofs[i], d[i]);
    wr(8'h3F, 8'hFF);
    for (i = 0; i < 4; i++) rd(ofs[i], d[i]);
    rd(8'h3F, 8'h00);
    @(negedge clk);
    chk("coeff", {d[2], d[3]}, bandpass_a2_coeff);
    // Bit two is read-only, bit seven drives dump enable
    wr(8'h40, 8'hEC);
    rd(8'h40, 8'hE8);
    @(negedge clk);
    chk("dump", 16'h0001, {15'h0, dump_enable});
    // Program with mask clear: event kept, irq quiet
    wr(8'h40, 8'h69);
    idle;
    chk("irq", 16'h0000, {15'h0, irq});
    rd(8'h40, 8'h6C);
    rd(8'h50, 8'h01);
    rd(8'h50, 8'h00);
    wr(8'h51, 8'hFF);
    rd(8'h51, 8'h07);
    // Reload must restore the programmed image
    for (i = 0; i < 4; i++) wr(ofs[i], ~d[i]);
    wr(8'h40, 8'h6A);
    idle;
    chk("irq", 16'h0001, {15'h0, irq});
    for (i = 0; i < 4; i++) rd(ofs[i], d[i]);
    rd(8'h40, 8'h6C);
    rd(8'h50, 8'h02);
    @(negedge clk);
    chk("irq", 16'h0000, {15'h0, irq});
    // Both triggers together
    wr(8'h40, 8'h6B);
    idle;
    rd(8'h40, 8'h6C);
    rd(8'h50, 8'h03);
    // Storage fault spoils the success flag
    @(posedge clk) ee_fault <= 1'b1;
    wr(8'h40, 8'h69);
    idle;
    @(posedge clk) ee_fault <= 1'b0;
    rd(8'h40, 8'h68);
    rd(8'h50, 8'h01);
    // Wrong passcode: dropped, flagged
    wr(8'h40, 8'h29);
    repeat (4) @(posedge clk);
    rd(8'h40, 8'h28);
    rd(8'h50, 8'h04);
    // Reset while idle; every register but status must read back zero
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 4; i++) rd(ofs[i], 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h51, 8'h00);
    @(negedge clk);
    chk("coeff_rst", 16'h0000, bandpass_a2_coeff);
    // Gain zones over every code of both fields
    for (i = 0; i < 16; i++) begin
      r = $random(seed);
      g = {r[31:30], 3'(i), 3'(i * 3)};
      wr(8'h2A, g);
      cp = 4'(r[3:0] % 4'd12) + 4'd1;
      far = r[4] && cp >= 4'd9 + 4'(g[7:6]);
      code = far ? g[5:3] : g[2:0];
      sh = (code > 3'h5) ? 3'h0 : code;
      nz = 7'(r[20:16]);
      g_q.push_back(13'(r[15:8]) << sh);
      @(posedge clk);
      cur_point <= cp;
      rec_active <= r[4];
      echo_sample <= r[15:8];
      noise_floor_setting <= r[20:16];
      echo_valid <= 1'b1;
      @(posedge clk);
      echo_valid <= 1'b0;
      repeat (2) @(negedge clk);
      nz = (g[5:3] == 3'h4) ? nz << 1 : (g[5:3] == 3'h5) ? nz << 2 : nz;
      chk("noise", {9'h0, nz}, {9'h0, noise_scaled});
      chk("code_err", {15'h0, g[5:4] == 2'h3 || g[2:1] == 2'h3},
        {15'h0, gain_code_err});
    end
    repeat (4) @(posedge clk);
    // Every queued result must have shown up
    chk("gain_left", 16'h0000, 16'(g_q.size()));
    chk("rd_left", 16'h0000, 16'(rd_q.size()));
    report_and_stop;
  end
endmodule
`default_nettype wire
